/* cfs_params.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef CFS_PARAMS_SVH
`define CFS_PARAMS_SVH

// Register byte offsets
`define CFS_OFS_CTRL 8'h00
`define CFS_OFS_SETPT 8'h04
`define CFS_OFS_DBAND 8'h08
`define CFS_OFS_SPDLIM 8'h0C
`define CFS_OFS_LFDLY 8'h10
`define CFS_OFS_GAIN 8'h14
`define CFS_OFS_MANUAL 8'h18
`define CFS_OFS_STEP0 8'h20
`define CFS_OFS_STATUS 8'h40
`define CFS_OFS_TEMP 8'h44
`define CFS_OFS_SPEED 8'h48

// Step configuration word fields
`define CFS_STP_OUT_LSB 0
`define CFS_STP_DRV_BIT 4
`define CFS_STP_EN_BIT 5
`define CFS_STP_LF_LSB 6
`define CFS_STP_DLY_LSB 16

// Reset values
`define CFS_RST_SETPT 16'h04B0
`define CFS_RST_DBAND 32'h0032_0032
`define CFS_RST_SPDLIM 16'h055F
`define CFS_RST_LFDLY 16'h000F
`define CFS_RST_GAIN 24'h00_0104
`define CFS_RST_STEP 32'h000F_0000

// Step count and drive scaling
`define CFS_NSTEP 5
`define CFS_SPEED_FULL 32'sd25600
`define CFS_DAC_4MA 12'd819
`define CFS_DAC_SPAN 32'd3276

// Timing: one second timer tick at the system clock period
`define CFS_TICK_NS 1000000000
`define CFS_CLK_NS 10
`define CFS_SEC_CYCLES (`CFS_TICK_NS / `CFS_CLK_NS)

`endif

/* cfs_pkg.sv */
// Types shared by the cooler step sequencer
package cfs_pkg;

    // Run mode selection held in the control register
    typedef enum logic [1:0] {
        CFS_RUN_NEVER = 2'h0,
        CFS_RUN_WITH_COMP = 2'h1,
        CFS_RUN_ALWAYS = 2'h2,
        CFS_RUN_MANUAL = 2'h3
    } cfs_mode_t;

endpackage : cfs_pkg

/* cfs_plant.sv */
// Relay contacts and drive model on the far side of the sequencer
`timescale 1ns/1ps
module cfs_plant (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] cooler_out,
    input wire logic [11:0] drive_dac,
    output logic [3:0] relay_on,
    output logic [7:0] drive_pct
);
    // Relays pick up one cycle after the coil; drive reads 4-20 mA as 0-100
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            relay_on <= 4'h0;
            drive_pct <= 8'h00;
        end else begin
            relay_on <= cooler_out;
            drive_pct <= 8'(((32'(drive_dac) - 32'd819) * 100) / 3276);
        end
    end
endmodule : cfs_plant

/* cfs_sequencer.sv */
// Cooler fan and pump step sequencer with APB registers and drive loop
`timescale 1ns/1ps
`include "cfs_params.svh"

module cfs_sequencer #(
    parameter int SEC_CYCLES = `CFS_SEC_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comp_running,
    input wire logic [15:0] aux5_temp,
    output logic [3:0] cooler_out,
    output logic [11:0] drive_dac,
    output logic [4:0] step_on
);

    // Configuration registers
    cfs_pkg::cfs_mode_t mode, next_mode;
    logic [15:0] setpt, next_setpt;
    logic [31:0] dband, next_dband;
    logic [15:0] spdlim, next_spdlim;
    logic [15:0] lfdly, next_lfdly;
    logic [23:0] gain, next_gain;
    logic [4:0] man_bits, next_man_bits;
    logic [31:0] step_cfg [`CFS_NSTEP];
    logic [31:0] next_step_cfg [`CFS_NSTEP];
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;

    // Input synchroniser and second tick
    logic [2:0] comp_sync;
    logic comp_q, next_comp_q;
    logic [31:0] pre_cnt, next_pre_cnt;
    logic tick, next_tick;

    // Sequencer state
    logic [2:0] level, next_level;
    logic [15:0] stp_cnt, next_stp_cnt;
    logic lf_pend, next_lf_pend;
    logic [3:0] lf_mask, next_lf_mask;
    logic [15:0] lf_cnt, next_lf_cnt;

    // Drive loop state
    logic signed [31:0] spd_acc, next_spd_acc;
    logic signed [16:0] err1, next_err1, err2, next_err2;
    logic [3:0] next_cooler_out;
    logic [11:0] next_drive_dac;
    logic [4:0] next_step_on;

    // Derived terms
    logic auto_run, hot, cold, drive_on, up_ok, dn_ok;
    logic want_up, want_dn;
    logic [2:0] up_idx, dn_idx;
    logic [4:0] en_mask, drv_mask, act_mask;
    logic [3:0] out_or;
    logic signed [16:0] temp_s, sp_s, err;
    logic [7:0] spd_pct;
    logic acc_wr;

    // Compressor running pin: three stages, change taken when last two agree
    always_comb begin
        next_comp_q = (comp_sync[2] == comp_sync[1]) ? comp_sync[2] : comp_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            comp_sync <= 3'h0;
            comp_q <= 1'b0;
        end else begin
            comp_sync <= {comp_sync[1:0], comp_running};
            comp_q <= next_comp_q;
        end
    end

    // One second tick for all step, fan and loop timers
    always_comb begin
        next_tick = 1'b0;
        next_pre_cnt = pre_cnt + 32'h0000_0001;
        if (pre_cnt >= 32'(SEC_CYCLES - 1)) begin
            next_pre_cnt = 32'h0000_0000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end else begin
            pre_cnt <= next_pre_cnt;
            tick <= next_tick;
        end
    end

    // APB slave: one wait state, registered answer, error on unmapped address
    always_comb begin
        next_mode = mode;
        next_setpt = setpt;
        next_dband = dband;
        next_spdlim = spdlim;
        next_lfdly = lfdly;
        next_gain = gain;
        next_man_bits = man_bits;
        for (int i = 0; i < `CFS_NSTEP; i++) begin
            next_step_cfg[i] = step_cfg[i];
        end
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        next_pready = 1'b0;
        acc_wr = psel && penable && !pready;
        if (acc_wr) begin
            next_pready = 1'b1;
            unique case (paddr)
                `CFS_OFS_CTRL: begin
                    next_prdata = {30'h0, mode};
                    if (pwrite) begin
                        next_mode = cfs_pkg::cfs_mode_t'(pwdata[1:0]);
                    end
                end
                `CFS_OFS_SETPT: begin
                    next_prdata = {16'h0000, setpt};
                    if (pwrite) next_setpt = pwdata[15:0];
                end
                `CFS_OFS_DBAND: begin
                    next_prdata = dband;
                    if (pwrite) next_dband = pwdata;
                end
                `CFS_OFS_SPDLIM: begin
                    next_prdata = {16'h0000, spdlim};
                    if (pwrite) next_spdlim = pwdata[15:0];
                end
                `CFS_OFS_LFDLY: begin
                    next_prdata = {16'h0000, lfdly};
                    if (pwrite) next_lfdly = pwdata[15:0];
                end
                `CFS_OFS_GAIN: begin
                    next_prdata = {8'h00, gain};
                    if (pwrite) next_gain = pwdata[23:0];
                end
                `CFS_OFS_MANUAL: begin
                    next_prdata = {27'h0, man_bits};
                    // Toggle writes land only in manual mode
                    if (pwrite && mode == cfs_pkg::CFS_RUN_MANUAL) begin
                        next_man_bits = man_bits ^ pwdata[4:0];
                    end
                end
                `CFS_OFS_STATUS: begin
                    next_prdata = {spd_pct, 7'h00, lf_pend,
                                   cooler_out, 3'h0, step_on, 1'b0, level};
                end
                `CFS_OFS_TEMP: begin
                    next_prdata = {16'h0000, aux5_temp};
                end
                `CFS_OFS_SPEED: begin
                    next_prdata = {8'h00, drive_dac, 4'h0, spd_pct};
                end
                default: begin
                    // Step configuration block, else unmapped
                    if (paddr >= `CFS_OFS_STEP0 &&
                        paddr < 8'(`CFS_OFS_STEP0 + 4 * `CFS_NSTEP) &&
                        paddr[1:0] == 2'h0) begin
                        next_prdata = step_cfg[3'(paddr[4:2])];
                        if (pwrite) begin
                            next_step_cfg[3'(paddr[4:2])] = pwdata;
                        end
                    end else begin
                        next_pslverr = 1'b1;
                    end
                end
            endcase
            if (!pwrite && next_pslverr) next_prdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= cfs_pkg::CFS_RUN_NEVER;
            setpt <= `CFS_RST_SETPT;
            dband <= `CFS_RST_DBAND;
            spdlim <= `CFS_RST_SPDLIM;
            lfdly <= `CFS_RST_LFDLY;
            gain <= `CFS_RST_GAIN;
            man_bits <= 5'h00;
            for (int i = 0; i < `CFS_NSTEP; i++) begin
                step_cfg[i] <= `CFS_RST_STEP;
            end
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            mode <= next_mode;
            setpt <= next_setpt;
            dband <= next_dband;
            spdlim <= next_spdlim;
            lfdly <= next_lfdly;
            gain <= next_gain;
            man_bits <= next_man_bits;
            for (int i = 0; i < `CFS_NSTEP; i++) begin
                step_cfg[i] <= next_step_cfg[i];
            end
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Band test, step masks and next enabled steps
    always_comb begin
        temp_s = {aux5_temp[15], aux5_temp};
        sp_s = {setpt[15], setpt};
        err = temp_s - sp_s;
        hot = temp_s > sp_s + $signed({1'b0, dband[15:0]});
        cold = temp_s < sp_s - $signed({1'b0, dband[31:16]});
        auto_run = (mode == cfs_pkg::CFS_RUN_ALWAYS) ||
                   (mode == cfs_pkg::CFS_RUN_WITH_COMP && comp_q);
        spd_pct = spd_acc[15:8];
        up_ok = 1'b0;
        dn_ok = 1'b0;
        up_idx = 3'h0;
        dn_idx = 3'h0;
        for (int i = 0; i < `CFS_NSTEP; i++) begin
            en_mask[i] = step_cfg[i][`CFS_STP_EN_BIT];
            drv_mask[i] = step_cfg[i][`CFS_STP_DRV_BIT];
            act_mask[i] = (mode == cfs_pkg::CFS_RUN_MANUAL) ? man_bits[i] :
                          (auto_run && 3'(i) < level && en_mask[i]);
        end
        // Skip disabled steps in both directions
        for (int i = `CFS_NSTEP - 1; i >= 0; i--) begin
            if (en_mask[i] && 3'(i) >= level) begin
                up_ok = 1'b1;
                up_idx = 3'(i);
            end
        end
        for (int i = 0; i < `CFS_NSTEP; i++) begin
            if (en_mask[i] && 3'(i) < level) begin
                dn_ok = 1'b1;
                dn_idx = 3'(i);
            end
        end
        drive_on = |(act_mask & drv_mask);
        // Speed limits gate stepping while the drive is in use
        want_up = hot && up_ok && !lf_pend &&
                  (!drive_on || spd_pct >= spdlim[7:0]);
        want_dn = cold && dn_ok &&
                  (!drive_on || spd_pct <= spdlim[15:8]);
    end

    // Automatic step sequencing with step and low-speed fan timers
    always_comb begin
        next_level = level;
        next_stp_cnt = stp_cnt;
        next_lf_pend = lf_pend;
        next_lf_mask = lf_mask;
        next_lf_cnt = lf_cnt;
        if (!auto_run) begin
            // Idle modes hold nothing over
            next_level = 3'h0;
            next_stp_cnt = 16'h0000;
            next_lf_pend = 1'b0;
            next_lf_mask = 4'h0;
            next_lf_cnt = 16'h0000;
        end else begin
            if (lf_pend && tick) begin
                next_lf_cnt = lf_cnt + 16'h0001;
                if (lf_cnt + 16'h0001 >= lfdly) begin
                    next_lf_pend = 1'b0;
                    next_lf_cnt = 16'h0000;
                end
            end
            if (want_up) begin
                if (tick) begin
                    next_stp_cnt = stp_cnt + 16'h0001;
                    // On-delay of the step being added
                    if (stp_cnt + 16'h0001 >=
                        step_cfg[up_idx][31:`CFS_STP_DLY_LSB]) begin
                        next_level = up_idx + 3'h1;
                        next_stp_cnt = 16'h0000;
                        if (step_cfg[up_idx][8:6] != 3'h0 &&
                            step_cfg[up_idx][8:6] <= 3'h4) begin
                            next_lf_pend = 1'b1;
                            next_lf_cnt = 16'h0000;
                            next_lf_mask = 4'h1 <<
                                (step_cfg[up_idx][7:6] - 2'h1);
                        end
                    end
                end
            end else if (want_dn) begin
                if (tick) begin
                    next_stp_cnt = stp_cnt + 16'h0001;
                    // Off-delay of the step being removed
                    if (stp_cnt + 16'h0001 >=
                        step_cfg[dn_idx][31:`CFS_STP_DLY_LSB]) begin
                        next_level = dn_idx;
                        next_stp_cnt = 16'h0000;
                        if (lf_pend && 3'(dn_idx + 3'h1) == level) begin
                            next_lf_pend = 1'b0;
                            next_lf_cnt = 16'h0000;
                        end
                    end
                end
            end else begin
                next_stp_cnt = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 3'h0;
            stp_cnt <= 16'h0000;
            lf_pend <= 1'b0;
            lf_mask <= 4'h0;
            lf_cnt <= 16'h0000;
        end else begin
            level <= next_level;
            stp_cnt <= next_stp_cnt;
            lf_pend <= next_lf_pend;
            lf_mask <= next_lf_mask;
            lf_cnt <= next_lf_cnt;
        end
    end

    // Velocity form PID, one update per second, clamped to 0..100 percent
    always_comb begin
        next_spd_acc = spd_acc;
        next_err1 = err1;
        next_err2 = err2;
        if (!drive_on) begin
            next_spd_acc = 32'sd0;
            next_err1 = 17'sd0;
            next_err2 = 17'sd0;
        end else if (tick) begin
            next_spd_acc = spd_acc
                + $signed({1'b0, gain[7:0]}) * 32'(err - err1)
                + $signed({1'b0, gain[15:8]}) * 32'(err)
                + $signed({1'b0, gain[23:16]}) *
                  32'(err - err1 - err1 + err2);
            if (next_spd_acc < 32'sd0) next_spd_acc = 32'sd0;
            if (next_spd_acc > `CFS_SPEED_FULL) begin
                next_spd_acc = `CFS_SPEED_FULL;
            end
            next_err1 = err;
            next_err2 = err1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spd_acc <= 32'sd0;
            err1 <= 17'sd0;
            err2 <= 17'sd0;
        end else begin
            spd_acc <= next_spd_acc;
            err1 <= next_err1;
            err2 <= next_err2;
        end
    end

    // Output drive: discrete outputs, drive current code, step indicators
    always_comb begin
        out_or = 4'h0;
        for (int i = 0; i < `CFS_NSTEP; i++) begin
            if (act_mask[i]) begin
                out_or = out_or | step_cfg[i][3:0];
            end
        end
        next_cooler_out = out_or & ~(lf_pend ? lf_mask : 4'h0);
        if (mode == cfs_pkg::CFS_RUN_NEVER) begin
            next_cooler_out = 4'h0;
        end
        // Zero speed sits at 4 mA, full speed at 20 mA
        next_drive_dac = drive_on ?
            `CFS_DAC_4MA + 12'((32'(spd_acc) * `CFS_DAC_SPAN) /
                               32'(`CFS_SPEED_FULL)) : `CFS_DAC_4MA;
        next_step_on = act_mask;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cooler_out <= 4'h0;
            drive_dac <= `CFS_DAC_4MA;
            step_on <= 5'h00;
        end else begin
            cooler_out <= next_cooler_out;
            drive_dac <= next_drive_dac;
            step_on <= next_step_on;
        end
    end

endmodule : cfs_sequencer

/* cfs_sequencer_asserts.sv */
// Port-level assertions for the cooler step sequencer
`timescale 1ns/1ps
module cfs_sequencer_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic comp_running,
    input wire logic [15:0] aux5_temp,
    input wire logic [3:0] cooler_out,
    input wire logic [11:0] drive_dac,
    input wire logic [4:0] step_on
);
    logic [1:0] mode;
    logic [1:0] next_mode;
    logic [2:0] stay;
    logic [2:0] next_stay;
    logic [2:0] cstop;
    logic [2:0] next_cstop;

    // Shadow of the mode field and how long it and the compressor held
    always_comb begin
        next_mode = mode;
        if (psel && penable && !pready && pwrite && paddr == 8'h00) begin
            next_mode = pwdata[1:0];
        end
        next_stay = (next_mode != mode) ? 3'h0 : stay + {2'h0, stay != 3'h7};
        next_cstop = comp_running ? 3'h0 : cstop + {2'h0, cstop != 3'h7};
    end

    // Registers the shadow state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= 2'h0;
            stay <= 3'h0;
            cstop <= 3'h0;
        end else begin
            mode <= next_mode;
            stay <= next_stay;
            cstop <= next_cstop;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_take;
        psel && penable && !pready;
    endsequence

    sequence s_answer;
        pready && psel && penable;
    endsequence

    a_ready_lat: assert property (s_take |=> s_answer)
        else $error("answer missing one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_err_pair: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    a_idle_data: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero outside answer");
    a_temp_read: assert property (
        s_answer and (!pwrite && paddr == 8'h44)
        |-> prdata[15:0] == $past(aux5_temp))
        else $error("temperature read differs from input");
    a_never_quiet: assert property (
        mode == 2'h0 && stay >= 3'h3
        |-> cooler_out == 4'h0 && step_on == 5'h00 && drive_dac == 12'd819)
        else $error("outputs active in never mode");
    a_dac_floor: assert property (drive_dac >= 12'd819)
        else $error("drive code below bottom of range");
    a_auto_single: assert property (
        mode == 2'h2 && stay >= 3'h3 && step_on != $past(step_on)
        |-> $countones(step_on ^ $past(step_on)) == 1)
        else $error("more than one step changed at once");
    a_comp_gate: assert property (
        mode == 2'h1 && stay >= 3'h6 && cstop >= 3'h6
        |-> step_on == 5'h00 && cooler_out == 4'h0)
        else $error("steps active with compressor stopped");
endmodule : cfs_sequencer_asserts

bind cfs_sequencer cfs_sequencer_asserts u_chk (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_running(comp_running), .aux5_temp(aux5_temp),
    .cooler_out(cooler_out), .drive_dac(drive_dac), .step_on(step_on));

/* tb.sv */
// Self-checking bench for the cooler step sequencer
`timescale 1ns/1ps
`include "cfs_params.svh"
module tb;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic comp_running = 0, pready, pslverr, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, r;
    logic [15:0] aux5_temp = 16'h0000;
    logic [3:0] cooler_out, relay_on;
    logic [11:0] drive_dac;
    logic [7:0] drive_pct;
    logic [4:0] step_on;
    logic [31:0] seed = 32'd87276;
    int n_errors = 0, checked = 0, cyc = 0;

    always #5 clk = ~clk;

    cfs_sequencer #(.SEC_CYCLES(10)) uut (.clk(clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comp_running(comp_running),
        .aux5_temp(aux5_temp), .cooler_out(cooler_out),
        .drive_dac(drive_dac), .step_on(step_on));
    cfs_plant u_plant (.clk(clk), .rst_n(rst_n), .cooler_out(cooler_out),
        .drive_dac(drive_dac), .relay_on(relay_on), .drive_pct(drive_pct));

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Step word: delay, low fan select, enable, drive, outputs
    function logic [31:0] cfg(logic [3:0] o, logic d, logic e, logic [2:0] lf,
                              logic [15:0] dl);
        return {dl, 7'h00, lf, e, d, o};
    endfunction : cfg

    task test_done;
        $display("Checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checked++;
        if (got !== ex) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // One APB transfer, held until ready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, ex, rd);
        chk("slverr", 32'h0, 32'(er));
    endtask : rchk

    task wait_step(input logic [4:0] v, input int lim);
        int n;
        n = 0;
        while (step_on !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk("step_on", 32'(v), 32'(step_on));
    endtask : wait_step

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            test_done();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk("ctrl", `CFS_OFS_CTRL, 32'h0000_0000);
        rchk("setpt", `CFS_OFS_SETPT, 32'h0000_04B0);
        rchk("dband", `CFS_OFS_DBAND, 32'h0032_0032);
        rchk("spdlim", `CFS_OFS_SPDLIM, 32'h0000_055F);
        rchk("gain", `CFS_OFS_GAIN, 32'h0000_0104);
        for (int i = 0; i < 5; i++) begin
            rchk("step", 8'(`CFS_OFS_STEP0 + 4*i), 32'h000F_0000);
        end
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk("slverr", 32'h1, 32'(er));
        repeat (4) begin
            r = rnd();
            aux5_temp <= {1'b0, r[14:0]};
            apb(1'b1, `CFS_OFS_TEMP, ~r);
            rchk("temp", `CFS_OFS_TEMP, {17'h0, r[14:0]});
            apb(1'b1, `CFS_OFS_SETPT, {17'h0, r[30:16]});
            rchk("setpt_rw", `CFS_OFS_SETPT, {17'h0, r[30:16]});
        end
        // Toggles outside manual mode must be ignored
        apb(1'b1, `CFS_OFS_MANUAL, 32'h0000_001F);
        chk("step_on", 32'h0, 32'(step_on));
        apb(1'b1, `CFS_OFS_STEP0, cfg(4'h1, 1'b0, 1'b1, 3'h0, 16'h0002));
        apb(1'b1, `CFS_OFS_STEP0 + 8'h08,
            cfg(4'h4, 1'b0, 1'b1, 3'h3, 16'h0003));
        apb(1'b1, `CFS_OFS_STEP0 + 8'h0C,
            cfg(4'hF, 1'b1, 1'b1, 3'h0, 16'h0002));
        apb(1'b1, `CFS_OFS_STEP0 + 8'h10,
            cfg(4'h2, 1'b0, 1'b1, 3'h0, 16'h0002));
        apb(1'b1, `CFS_OFS_LFDLY, 32'h0000_0003);
        apb(1'b1, `CFS_OFS_SETPT, 32'h0000_03E8);
        // Manual stepping
        apb(1'b1, `CFS_OFS_CTRL, 32'h0000_0003);
        apb(1'b1, `CFS_OFS_MANUAL, 32'h0000_0009);
        chk("step_on", 32'h09, 32'(step_on));
        chk("cooler_out", 32'hF, 32'(cooler_out));
        apb(1'b1, `CFS_OFS_MANUAL, 32'h0000_0001);
        chk("step_on", 32'h08, 32'(step_on));
        apb(1'b1, `CFS_OFS_CTRL, 32'h0000_0000);
        repeat (4) @(posedge clk);
        chk("cooler_out", 32'h0, 32'(cooler_out));
        chk("drive_dac", 32'd819, 32'(drive_dac));
        // Automatic stepping, always mode
        aux5_temp <= 16'd1050;
        apb(1'b1, `CFS_OFS_CTRL, 32'h0000_0002);
        repeat (60) @(posedge clk);
        chk("step_on", 32'h0, 32'(step_on));
        aux5_temp <= 16'd1051;
        repeat (10) @(posedge clk);
        chk("step_on", 32'h0, 32'(step_on));
        wait_step(5'h01, 40);
        wait_step(5'h05, 60);
        repeat (2) @(posedge clk);
        chk("cooler_out", 32'h1, 32'(cooler_out));
        for (int n = 0; n < 60 && cooler_out !== 4'h5; n++) @(posedge clk);
        chk("cooler_out", 32'h5, 32'(cooler_out));
        repeat (10) @(posedge clk);
        chk("step_on", 32'h05, 32'(step_on));
        wait_step(5'h0D, 40);
        aux5_temp <= 16'd1300;
        repeat (100) @(posedge clk);
        chk("step_on", 32'h0D, 32'(step_on));
        wait_step(5'h1D, 3000);
        for (int n = 0; n < 3000 && drive_dac !== 12'd4095; n++)
            @(posedge clk);
        repeat (2) @(posedge clk);
        chk("drive_pct", 32'd100, 32'(drive_pct));
        rchk("speed", `CFS_OFS_SPEED,
             {8'h00, 12'd4095, 4'h0, 8'd100});
        aux5_temp <= 16'd900;
        repeat (100) @(posedge clk);
        chk("step_on", 32'h1D, 32'(step_on));
        wait_step(5'h0D, 4000);
        wait_step(5'h00, 400);
        // Compressor-gated mode
        aux5_temp <= 16'd1051;
        apb(1'b1, `CFS_OFS_CTRL, 32'h0000_0001);
        repeat (60) @(posedge clk);
        chk("step_on", 32'h0, 32'(step_on));
        comp_running <= 1'b1;
        wait_step(5'h01, 60);
        comp_running <= 1'b0;
        repeat (12) @(posedge clk);
        chk("relay_on", 32'h0, 32'(relay_on));
        comp_running <= 1'b1;
        wait_step(5'h01, 60);
        rst_n <= 1'b0;
        @(posedge clk);
        chk("step_on", 32'h0, 32'(step_on));
        rst_n <= 1'b1;
        @(posedge clk);
        rchk("ctrl", `CFS_OFS_CTRL, 32'h0000_0000);
        test_done();
    end
endmodule : tb
